// ==== srl_defs.vh ====
/*
 Constants for the set/reset latch source-select block: register
 offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SRL_DEFS_VH
`define SRL_DEFS_VH

`define SRL_OFF_CTRL      12'h000
`define SRL_OFF_SRC       12'h004
`define SRL_OFF_STATUS    12'h008

`define SRL_CTRL_RST      8'h00
`define SRL_SRC_RST       8'h00

`define SRL_C_LEN         7
`define SRL_C_DIV_HI      6
`define SRL_C_DIV_LO      4
`define SRL_C_QEN         3
`define SRL_C_NQEN        2
`define SRL_C_PS          1
`define SRL_C_PR          0

`define SRL_S_PIN_SET     7
`define SRL_S_CLK_SET     6
`define SRL_S_C2_SET      5
`define SRL_S_C1_SET      4
`define SRL_S_PIN_RST     3
`define SRL_S_CLK_RST     2
`define SRL_S_C2_RST      1
`define SRL_S_C1_RST      0

`define SRL_PULSE_CYC     2'd2
`define SRL_DIV_BASE_LOG  4'd2

`endif

// ==== srl_latch.v ====
/*
 Set/reset latch with selectable set and reset sources, an APB
 register slave, a divided periodic clock and software pulses.
 Assumes comparator outputs and the latch input pin are asynchronous
 to pclk; the pins are driven from flip-flops.
*/
//
// Function
// - Pin-set enable lets input pin set
// - Clock-set enable routes divided clock to Set
// - Bit 5 lets comparator 2 set
// - Bit 4 lets comparator 1 set
// - Pin-reset enable lets input pin reset
// - Clock-reset enable routes divided clock to Reset
// - Bit 1 lets comparator 2 reset
// - Bit 0 lets comparator 1 reset
// - Source enables read/write, reset to zero
// - Reset dominates when both inputs high
// - Soft pulses last two cycles, read zero
// - Divider codes select period 4 to 512
// - Output enables gate Q and inverted pins
`timescale 1ns/1ps
`default_nettype none
`include "srl_defs.vh"

module srl_latch #(
	parameter DIV_W = 9
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        latch_input_pin,
	input  wire        cmp1_out,
	input  wire        cmp2_out,
	output reg         srq_pin,
	output reg         srq_pin_oe,
	output reg         srnq_pin,
	output reg         srnq_pin_oe,
	output reg         latch_q
);

	reg  [7:0]       ctrl_r;
	reg  [7:0]       src_r;
	reg  [DIV_W-1:0] div_cnt_r;
	reg  [1:0]       clk_pulse_r;
	reg  [1:0]       ps_cnt_r;
	reg  [1:0]       pr_cnt_r;
	reg  [31:0]      prdata_r;
	reg              q_nxt;

	wire        wr_en;
	wire        rd_en;
	wire        addr_ok;
	wire        pin_s;
	wire        c1_s;
	wire        c2_s;
	wire        div_clk;
	wire        soft_set;
	wire        soft_rst;
	wire        set_in;
	wire        rst_in;
	wire [2:0]  div_sel;
	wire [DIV_W-1:0] div_last;
	wire        ctrl_wr;
	wire        src_wr;
	wire        ps_start;
	wire        pr_start;
	wire        div_tick;
	wire [2:0]  async_in;
	wire [2:0]  sync_out;

	function [31:0] rd_word;
		input [11:0] a;
		input [7:0]  ctrl;
		input [7:0]  src;
		input        q;
		begin
			case (a)
			`SRL_OFF_CTRL:   rd_word = {24'h00_0000, ctrl};
			`SRL_OFF_SRC:    rd_word = {24'h00_0000, src};
			`SRL_OFF_STATUS: rd_word = {31'h0000_0000, q};
			default:         rd_word = 32'h0000_0000;
			endcase
		end
	endfunction

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `SRL_OFF_CTRL) || (a == `SRL_OFF_SRC) ||
				(a == `SRL_OFF_STATUS);
		end
	endfunction

	// Single-cycle access phase; pready always high
	assign addr_ok = is_mapped(paddr);
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = prdata_r;
	assign ctrl_wr = wr_en & (paddr == `SRL_OFF_CTRL);
	assign src_wr  = wr_en & (paddr == `SRL_OFF_SRC);

	// Two flops before any logic sees the asynchronous sources
	assign async_in = {latch_input_pin, cmp2_out, cmp1_out};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_sync
			reg meta_r;
			reg stable_r;
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_r   <= 1'b0;
					stable_r <= 1'b0;
				end
				else
				begin
					meta_r   <= async_in[gi];
					stable_r <= meta_r;
				end
			end
			assign sync_out[gi] = stable_r;
		end
	endgenerate

	// Idle level of every source is low, so reset gives no false set
	assign pin_s = sync_out[2];
	assign c2_s  = sync_out[1];
	assign c1_s  = sync_out[0];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= `SRL_CTRL_RST;
			src_r  <= `SRL_SRC_RST;
		end
		else if (ctrl_wr)
		begin
			// Pulse bits never stored, so they read back zero
			ctrl_r <= {pwdata[7:2], 2'b00};
		end
		else if (src_wr)
		begin
			src_r <= pwdata[7:0];
		end
	end

	// Read data registered in the setup cycle, valid in access
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (rd_en)
		begin
			prdata_r <= rd_word(paddr, ctrl_r, src_r, latch_q);
		end
	end

	// Software pulses: two pclk cycles each
	assign ps_start = ctrl_wr & pwdata[`SRL_C_PS];
	assign pr_start = ctrl_wr & pwdata[`SRL_C_PR];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ps_cnt_r <= 2'd0;
		end
		else if (ps_start)
		begin
			ps_cnt_r <= `SRL_PULSE_CYC;
		end
		else if (ps_cnt_r != 2'd0)
		begin
			ps_cnt_r <= ps_cnt_r - 2'd1;
		end
	end

	// A new write restarts a running pulse rather than queueing it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pr_cnt_r <= 2'd0;
		end
		else if (pr_start)
		begin
			pr_cnt_r <= `SRL_PULSE_CYC;
		end
		else if (pr_cnt_r != 2'd0)
		begin
			pr_cnt_r <= pr_cnt_r - 2'd1;
		end
	end
	assign soft_set = (ps_cnt_r != 2'd0);
	assign soft_rst = (pr_cnt_r != 2'd0);

	// Divided clock: 2-cycle pulse every 4 << code cycles.
	// Changing the code mid-count may give one odd period.
	assign div_sel  = ctrl_r[`SRL_C_DIV_HI:`SRL_C_DIV_LO];
	assign div_last = ({{(DIV_W-1){1'b0}}, 1'b1}
		<< (div_sel + `SRL_DIV_BASE_LOG)) - {{(DIV_W-1){1'b0}}, 1'b1};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_r   <= {DIV_W{1'b0}};
			clk_pulse_r <= 2'b00;
		end
		else
		begin
			if (div_tick)
			begin
				div_cnt_r <= {DIV_W{1'b0}};
			end
			else
			begin
				div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			end
			clk_pulse_r <= {clk_pulse_r[0], div_tick};
		end
	end
	// Compare with >= so a code lowered mid-count wraps at once
	assign div_tick = (div_cnt_r >= div_last);
	assign div_clk = |clk_pulse_r;

	assign set_in = (src_r[`SRL_S_PIN_SET] & pin_s)
		| (src_r[`SRL_S_CLK_SET] & div_clk)
		| (src_r[`SRL_S_C2_SET] & c2_s)
		| (src_r[`SRL_S_C1_SET] & c1_s)
		| soft_set;
	assign rst_in = (src_r[`SRL_S_PIN_RST] & pin_s)
		| (src_r[`SRL_S_CLK_RST] & div_clk)
		| (src_r[`SRL_S_C2_RST] & c2_s)
		| (src_r[`SRL_S_C1_RST] & c1_s)
		| soft_rst;

	always @*
	begin
		if (!ctrl_r[`SRL_C_LEN])
			q_nxt = latch_q;
		else if (rst_in)
			q_nxt = 1'b0;
		else if (set_in)
			q_nxt = 1'b1;
		else
			q_nxt = latch_q;
	end

	// Latch sampled on pclk so it has a defined reset value
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			latch_q <= 1'b0;
		end
		else
		begin
			latch_q <= q_nxt;
		end
	end

	// Pin data follows Q even while its driver is off
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			srq_pin    <= 1'b0;
			srq_pin_oe <= 1'b0;
		end
		else
		begin
			srq_pin    <= q_nxt;
			srq_pin_oe <= ctrl_r[`SRL_C_QEN];
		end
	end

	// Inverted pin enabled independently of the true pin
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			srnq_pin    <= 1'b0;
			srnq_pin_oe <= 1'b0;
		end
		else
		begin
			srnq_pin    <= ~q_nxt;
			srnq_pin_oe <= ctrl_r[`SRL_C_NQEN];
		end
	end

endmodule
`default_nettype wire

// ==== srl_latch_props.sv ====
/* Checker for srl_latch register port.
 Assumes the bind below and one clock. */
`timescale 1ns/1ps
`default_nettype none
module srl_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        latch_q
);
	wire acc = psel && penable;
	wire rd = acc && !pwrite;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_no_wait: assert property (acc |-> pready) else $error("wait");
	a_bad_addr: assert property (acc && paddr > 12'h008 |-> pslverr)
		else $error("not refused");
	a_good_addr: assert property (acc && (paddr == 12'h000 ||
		paddr == 12'h004 || paddr == 12'h008) |-> !pslverr)
		else $error("refused");
	a_err_acc: assert property (pslverr |-> acc) else $error("stray");
	a_err_data: assert property (rd && pslverr |-> prdata == 32'h0)
		else $error("data");
	a_pulse_rd: assert property (rd && paddr == 12'h000 |->
		prdata[1:0] == 2'b00) else $error("pulse");
	a_upper_rd: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("upper");
	a_status_rd: assert property (rd && paddr == 12'h008 |->
		prdata[0] == $past(latch_q)) else $error("status");
endmodule
bind srl_latch srl_props u_props (.*);
`default_nettype wire

// ==== srl_src_model.sv ====
/* Far-side model: latch input pin, comparators.
 Assumes want holds {pin, cmp2, cmp1}. */
`timescale 1ns/1ps
`default_nettype none
module srl_src_model (
	input wire logic       pclk,
	input wire logic [2:0] want,
	output var logic [2:0] lvl = 3'h0
);
	// Async sources: move off the sampling edge
	always @(negedge pclk) lvl <= want;
endmodule
`default_nettype wire

// ==== srl_latch_tb_top.sv ====
/* Bench for srl_latch: APB master and scenarios.
 Assumes checker and source model compile first. */
`timescale 1ns/1ps
`default_nettype none
module srl_latch_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, latch_q, srq_pin, srnq_pin;
	logic srq_pin_oe, srnq_pin_oe, latch_input_pin, cmp1_out, cmp2_out;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic [2:0] want = 3'h0;
	int bad_count, checked, cyc, t0, i;
	srl_latch u_dut (.*);
	srl_src_model u_src (.pclk, .want,
		.lvl({latch_input_pin, cmp2_out, cmp1_out}));
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic chk(logic [31:0] e, g, string s);
		checked++;
		bad_count += (g !== e);
		if (g !== e)
			$display("ERROR %s exp %h got %h", s, e, g);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 60 && pready !== 1'b1; k++)
			@(posedge pclk);
		chk(1'b1, pready, "ready");
		if (pready !== 1'b1)
			test_done;
		d = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task automatic hit(logic v);
		for (int k = 0; k < 600 && latch_q !== v; k++)
			@(posedge pclk);
		chk(v, latch_q, "wait");
		if (latch_q !== v)
			test_done;
	endtask
	task automatic t_regs;
		apb(0, 12'h004, 32'h0);
		chk(32'h0, d, "src");
		apb(1, 12'h004, 32'ha5);
		apb(0, 12'h004, 32'h0);
		chk(32'ha5, d, "rw");
		apb(1, 12'h004, 32'h0);
		apb(0, 12'h00c, 32'h0);
		chk(32'h0, d, "unmapped");
		apb(0, 12'h008, 32'h0);
		chk(32'h0, d, "status");
		apb(1, 12'h000, 32'h86);
		apb(1, 12'h000, 32'h8b);
		apb(0, 12'h000, 32'h0);
		chk(32'h88, d, "ctrl");
		chk(3'b100, {srq_pin_oe, srnq_pin_oe, latch_q}, "oe");
	endtask
	task automatic t_src(int b);
		logic s = b > 3;
		apb(1, 12'h000, s ? 32'h81 : 32'h82);
		want <= b[1:0] == 2'd3 ? 3'h4 : b[1:0] == 2'd1 ? 3'h2 : {2'h0, !b[1]};
		repeat (8) @(posedge pclk);
		chk(!s, latch_q, "gate");
		apb(1, 12'h004, 32'h1 << b);
		repeat (8) @(posedge pclk);
		chk(s, latch_q, "route");
		want <= 3'h0;
		apb(1, 12'h004, 32'h0);
	endtask
	task automatic t_div(logic [2:0] c);
		apb(1, 12'h000, {25'h1, c, 4'h1});
		apb(1, 12'h004, 32'h48);
		hit(1'b1);
		want <= 3'h4;
		@(posedge pclk);
		want <= 3'h0;
		hit(1'b0);
		hit(1'b1);
		t0 = cyc;
		want <= 3'h4;
		@(posedge pclk);
		want <= 3'h0;
		hit(1'b0);
		hit(1'b1);
		chk(32'h4 << c, cyc - t0, "period");
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		for (i = 0; i < 8; i++)
			t_src(i);
		for (i = 1; i < 8; i++)
			t_div(i[2:0]);
		test_done;
	end
endmodule
`default_nettype wire
